/* efc_pkg.sv */
// Shared constants and carrier types for the E1 framer control bank
`default_nettype none
package efc_pkg;
    // Register byte addresses on the multiplexed parallel port
    localparam logic [7:0] EFC_ADDR_RX2 = 8'h11;
    localparam logic [7:0] EFC_ADDR_TX1 = 8'h12;
    localparam logic [7:0] EFC_ADDR_TX2 = 8'h13;
    localparam logic [7:0] EFC_ADDR_CC1 = 8'h14;
    // Reset values and writable masks (unassigned bits read as zero)
    localparam logic [7:0] EFC_RST_VAL  = 8'h00;
    localparam logic [7:0] EFC_MASK_RX2 = 8'hFE;
    localparam logic [7:0] EFC_MASK_TX1 = 8'h7F;
    localparam logic [7:0] EFC_MASK_TX2 = 8'hFB;
    localparam logic [7:0] EFC_MASK_CC1 = 8'hFF;
    localparam logic [7:0] EFC_RD_NONE  = 8'h00;
    // Field positions: rx control two
    localparam int RX2_RATE_BIT   = 2;
    localparam int RX2_SLIP_BIT   = 1;
    // Field positions: tx control one
    localparam int TX1_PT_BIT     = 6;
    localparam int TX1_TS16_BIT   = 5;
    localparam int TX1_UA1_BIT    = 4;
    localparam int TX1_SI_BIT     = 3;
    localparam int TX1_SA1_BIT    = 2;
    localparam int TX1_MODE_BIT   = 1;
    localparam int TX1_DIR_BIT    = 0;
    // Field positions: tx control two
    localparam int TX2_EBIT_BIT   = 1;
    localparam int TX2_PIN_BIT    = 0;
    // Field positions: common control one
    localparam int CC1_LOOP_BIT   = 7;
    localparam int CC1_THDB_BIT   = 6;
    localparam int CC1_TBLK_BIT   = 5;
    localparam int CC1_TCRC_BIT   = 4;
    localparam int CC1_SIGM_BIT   = 3;
    localparam int CC1_RHDB_BIT   = 2;
    localparam int CC1_RBLK_BIT   = 1;
    localparam int CC1_RCRC_BIT   = 0;
    // Frame geometry; bit index 0 is bit 1 of a timeslot, sent first
    localparam logic [4:0] EFC_TS_ALIGN = 5'h00;
    localparam logic [4:0] EFC_TS_SIG   = 5'h10;
    localparam logic [4:0] EFC_TS_BLOCK = 5'h1A;
    localparam logic [2:0] EFC_BIT_ONE  = 3'h0;
    localparam logic [2:0] EFC_BIT_LAST = 3'h7;
    localparam logic [2:0] EFC_SA_FIRST = 3'h3;
    localparam logic [7:0] EFC_SIG_ONES = 8'hFF;

    // One bit slot of a framer direction
    typedef struct packed {
        logic       stb;
        logic [4:0] ts;
        logic [2:0] bit_idx;
        logic       nonalign;
    } efc_slot_s;

    // Multiplexed parallel port pins, separate active-low read and write strobes
    typedef struct packed {
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] ad;
    } efc_bus_s;

    typedef struct packed {
        logic [7:0] rx2;
        logic [7:0] tx1;
        logic [7:0] tx2;
        logic [7:0] cc1;
    } efc_regs_s;

    typedef struct packed {
        efc_regs_s  regs;
        logic [7:0] addr;
        logic       ale_q;
        logic       wr_n_q;
        logic [7:0] wdata;
        logic [7:0] rd_data;
        logic       rd_drive;
        logic       tx_bit;
        logic       tx_pos;
        logic       tx_neg;
        logic       ami_pol;
        logic       rx_link;
        logic       rx_link_vld;
        logic       sync_out;
    } efc_state_s;

    typedef struct packed {
        logic chblk;
    } efc_blk_state_s;
endpackage : efc_pkg
`default_nettype wire

/* efc_chblk_gen.sv */
// Channel-block output generator with forced timeslot 26 bit 1
`timescale 1ns/1ps
`default_nettype none
module efc_chblk_gen
    import efc_pkg::*;
#(
    parameter logic [4:0] BLOCK_TS  = EFC_TS_BLOCK,
    parameter logic [2:0] BLOCK_BIT = EFC_BIT_ONE
) (
    input  wire logic      mclk_i,
    input  wire logic      rst_n_i,
    input  wire logic      ce_i,
    input  wire efc_slot_s slot_i,
    input  wire logic      force_en_i,
    input  wire logic      base_i,
    output logic           chblk_o
);
    efc_blk_state_s s_r;
    efc_blk_state_s s_nxt;
    logic           hit;

    // Slot hit marks the G.802 blocking position
    assign hit = (slot_i.ts == BLOCK_TS) && (slot_i.bit_idx == BLOCK_BIT);

    // Base pattern from the blocking map, forced high at the hit slot when enabled
    always_comb begin
        s_nxt = s_r;
        if (slot_i.stb) begin
            s_nxt.chblk = base_i | (force_en_i & hit);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign chblk_o = s_r.chblk;

    a_ts26_force: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && slot_i.stb && force_en_i && hit) |=> chblk_o)
        else $error("channel block not forced at timeslot 26 bit 1");
endmodule : efc_chblk_gen
`default_nettype wire

/* efc_ctrl_bank.sv */
// E1 framer control bank: host register port and the paths it steers
`timescale 1ns/1ps
`default_nettype none
module efc_ctrl_bank
    import efc_pkg::*;
(
    input  wire logic      mclk_i,
    input  wire logic      rst_n_i,
    input  wire logic      ce_i,
    // Host parallel port
    input  wire efc_bus_s  bus_i,
    output logic [7:0]     ad_o,
    output logic           ad_oe_n_o,
    // Transmit slot and sources
    input  wire efc_slot_s tx_slot_i,
    input  wire logic      tx_serial_in_i,
    input  wire logic      tx_link_in_i,
    input  wire logic [7:0] tx_align_word_reg_i,
    input  wire logic [7:0] tx_nonalign_word_reg_i,
    input  wire logic      tx_sig_reg_bit_i,
    input  wire logic      tx_frame_start_i,
    input  wire logic      tx_mframe_start_i,
    input  wire logic      tx_blk_map_i,
    output logic           tx_data_o,
    output logic           tx_positive_out_o,
    output logic           tx_negative_out_o,
    output logic           tx_channel_block_out_o,
    // Transmit sync pin, two-way
    input  wire logic      tx_sync_pin_i,
    output logic           tx_sync_pin_o,
    output logic           tx_sync_pin_oe_n_o,
    output logic           tx_sync_seen_o,
    // Receive slot and sources
    input  wire efc_slot_s rx_slot_i,
    input  wire logic      rx_line_data_i,
    input  wire logic      rx_blk_map_i,
    output logic           rx_framer_data_o,
    output logic           rx_link_out_o,
    output logic           rx_link_valid_o,
    output logic           rx_channel_block_out_o,
    // Shared status pin
    input  wire logic      rx_sync_loss_i,
    input  wire logic      tx_clock_loss_i,
    output logic           shared_pin_o,
    // Configuration levels for the framer datapaths
    output logic           rx_backplane_clock_rate_o,
    output logic           rx_slip_buffer_enable_o,
    output logic           tx_sync_mode_o,
    output logic           auto_ebit_enable_o,
    output logic           rx_signaling_mode_o,
    output logic           framer_loopback_o,
    output logic           tx_zero_sub_enable_o,
    output logic           rx_zero_sub_enable_o,
    output logic           tx_multiframe_check_enable_o,
    output logic           rx_multiframe_check_enable_o
);
    efc_state_s s_r;
    efc_state_s s_nxt;
    logic       wr_commit;
    logic       tx_bit_sel;
    logic       rx_src;
    logic [2:0] tx_word_idx;
    logic [7:0] rd_lookup;
    logic       rx_is_sa;

    // Write commits when the write strobe rises; data was held while low
    assign wr_commit = !s_r.wr_n_q && bus_i.wr_n;

    // Internal word bits go out MSB first, bit 1 of the slot first
    assign tx_word_idx = EFC_BIT_LAST - tx_slot_i.bit_idx;

    // Read lookup; unmapped addresses answer zero
    always_comb begin
        case (s_r.addr)
            EFC_ADDR_RX2: rd_lookup = s_r.regs.rx2;
            EFC_ADDR_TX1: rd_lookup = s_r.regs.tx1;
            EFC_ADDR_TX2: rd_lookup = s_r.regs.tx2;
            EFC_ADDR_CC1: rd_lookup = s_r.regs.cc1;
            default:      rd_lookup = EFC_RD_NONE;
        endcase
    end

    // Transmit bit source selection for the current slot
    always_comb begin
        tx_bit_sel = tx_serial_in_i;
        if (s_r.regs.tx1[TX1_UA1_BIT]) begin
            tx_bit_sel = 1'b1;
        end else if (tx_slot_i.ts == EFC_TS_ALIGN) begin
            if (tx_slot_i.bit_idx == EFC_BIT_ONE) begin
                // Si bit follows its own select even if pass-through was misprogrammed
                if (s_r.regs.tx1[TX1_SI_BIT]) begin
                    tx_bit_sel = tx_slot_i.nonalign ? tx_nonalign_word_reg_i[tx_word_idx]
                                                    : tx_align_word_reg_i[tx_word_idx];
                end else begin
                    tx_bit_sel = tx_serial_in_i;
                end
            end else if (s_r.regs.tx1[TX1_PT_BIT]) begin
                tx_bit_sel = tx_serial_in_i;
            end else if (tx_slot_i.nonalign && tx_slot_i.bit_idx >= EFC_SA_FIRST
                         && s_r.regs.tx2[tx_slot_i.bit_idx]) begin
                tx_bit_sel = tx_link_in_i;
            end else begin
                tx_bit_sel = tx_slot_i.nonalign ? tx_nonalign_word_reg_i[tx_word_idx]
                                                : tx_align_word_reg_i[tx_word_idx];
            end
        end else if (tx_slot_i.ts == EFC_TS_SIG) begin
            if (s_r.regs.tx1[TX1_SA1_BIT]) begin
                tx_bit_sel = EFC_SIG_ONES[tx_word_idx];
            end else if (s_r.regs.tx1[TX1_TS16_BIT]) begin
                tx_bit_sel = tx_sig_reg_bit_i;
            end else begin
                tx_bit_sel = tx_serial_in_i;
            end
        end
    end

    // Loopback swaps the receive source; the line input is then ignored
    assign rx_src = s_r.regs.cc1[CC1_LOOP_BIT] ? s_r.tx_bit : rx_line_data_i;

    // Receive Sa bits live in bits 4..8 of timeslot 0 in non-align frames
    assign rx_is_sa = (rx_slot_i.ts == EFC_TS_ALIGN) && rx_slot_i.nonalign
                      && (rx_slot_i.bit_idx >= EFC_SA_FIRST);

    // Next-state logic for the bus port, transmit rails and receive link
    always_comb begin
        s_nxt          = s_r;
        s_nxt.ale_q    = bus_i.ale;
        s_nxt.wr_n_q   = bus_i.wr_n;
        s_nxt.rd_data  = rd_lookup;
        s_nxt.rd_drive = !bus_i.rd_n;
        // Address is latched at the falling edge of the latch enable
        if (s_r.ale_q && !bus_i.ale) begin
            s_nxt.addr = bus_i.ad;
        end
        if (!bus_i.wr_n) begin
            s_nxt.wdata = bus_i.ad;
        end
        // Unassigned bits are masked so they always read back as zero
        if (wr_commit) begin
            case (s_r.addr)
                EFC_ADDR_RX2: s_nxt.regs.rx2 = s_r.wdata & EFC_MASK_RX2;
                EFC_ADDR_TX1: s_nxt.regs.tx1 = s_r.wdata & EFC_MASK_TX1;
                EFC_ADDR_TX2: s_nxt.regs.tx2 = s_r.wdata & EFC_MASK_TX2;
                EFC_ADDR_CC1: s_nxt.regs.cc1 = s_r.wdata & EFC_MASK_CC1;
                default:      s_nxt.regs     = s_r.regs;
            endcase
        end
        // AMI rails; HDB3 substitution is left to the line coder downstream
        if (tx_slot_i.stb) begin
            s_nxt.tx_bit = tx_bit_sel;
            s_nxt.tx_pos = tx_bit_sel && !s_r.ami_pol;
            s_nxt.tx_neg = tx_bit_sel && s_r.ami_pol;
            if (tx_bit_sel) begin
                s_nxt.ami_pol = !s_r.ami_pol;
            end
        end
        // Receive link holds the last reported Sa bit until the next one
        s_nxt.rx_link_vld = 1'b0;
        if (rx_slot_i.stb && rx_is_sa && s_r.regs.rx2[rx_slot_i.bit_idx]) begin
            s_nxt.rx_link     = rx_src;
            s_nxt.rx_link_vld = 1'b1;
        end
        // Sync pulse comes from the boundary picked by the mode bit
        s_nxt.sync_out = s_r.regs.tx1[TX1_MODE_BIT] ? tx_mframe_start_i
                                                     : tx_frame_start_i;
    end

    // One register stage for all state, frozen while the clock enable is low
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r          <= '0;
            s_r.regs.rx2 <= EFC_RST_VAL;
            s_r.regs.tx1 <= EFC_RST_VAL;
            s_r.regs.tx2 <= EFC_RST_VAL;
            s_r.regs.cc1 <= EFC_RST_VAL;
            s_r.ale_q    <= 1'b0;
            s_r.wr_n_q   <= 1'b1;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // Channel-block generators, one per direction
    efc_chblk_gen #(
        .BLOCK_TS  (EFC_TS_BLOCK),
        .BLOCK_BIT (EFC_BIT_ONE)
    ) u_tx_blk (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .slot_i     (tx_slot_i),
        .force_en_i (s_r.regs.cc1[CC1_TBLK_BIT]),
        .base_i     (tx_blk_map_i),
        .chblk_o    (tx_channel_block_out_o)
    );

    efc_chblk_gen #(
        .BLOCK_TS  (EFC_TS_BLOCK),
        .BLOCK_BIT (EFC_BIT_ONE)
    ) u_rx_blk (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .slot_i     (rx_slot_i),
        .force_en_i (s_r.regs.cc1[CC1_RBLK_BIT]),
        .base_i     (rx_blk_map_i),
        .chblk_o    (rx_channel_block_out_o)
    );

    // Port outputs
    assign ad_o               = s_r.rd_data;
    assign ad_oe_n_o          = !s_r.rd_drive;
    assign tx_data_o          = s_r.tx_bit;
    assign tx_positive_out_o  = s_r.tx_pos;
    assign tx_negative_out_o  = s_r.tx_neg;
    assign rx_framer_data_o   = rx_src;
    assign rx_link_out_o      = s_r.rx_link;
    assign rx_link_valid_o    = s_r.rx_link_vld;
    assign tx_sync_pin_o      = s_r.sync_out;
    assign tx_sync_pin_oe_n_o = !s_r.regs.tx1[TX1_DIR_BIT];
    // Framer sees its own pulse when driving, else the external pin
    assign tx_sync_seen_o     = s_r.regs.tx1[TX1_DIR_BIT] ? s_r.sync_out : tx_sync_pin_i;
    assign shared_pin_o       = s_r.regs.tx2[TX2_PIN_BIT] ? tx_clock_loss_i
                                                          : rx_sync_loss_i;

    // Configuration levels straight from the bank
    assign rx_backplane_clock_rate_o    = s_r.regs.rx2[RX2_RATE_BIT];
    assign rx_slip_buffer_enable_o      = s_r.regs.rx2[RX2_SLIP_BIT];
    assign tx_sync_mode_o               = s_r.regs.tx1[TX1_MODE_BIT];
    assign auto_ebit_enable_o           = s_r.regs.tx2[TX2_EBIT_BIT];
    assign rx_signaling_mode_o          = s_r.regs.cc1[CC1_SIGM_BIT];
    assign framer_loopback_o            = s_r.regs.cc1[CC1_LOOP_BIT];
    assign tx_zero_sub_enable_o         = s_r.regs.cc1[CC1_THDB_BIT];
    assign rx_zero_sub_enable_o         = s_r.regs.cc1[CC1_RHDB_BIT];
    assign tx_multiframe_check_enable_o = s_r.regs.cc1[CC1_TCRC_BIT];
    assign rx_multiframe_check_enable_o = s_r.regs.cc1[CC1_RCRC_BIT];

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_tx_slot_ts0_internal;
        ce_i && tx_slot_i.stb && !s_r.regs.tx1[TX1_UA1_BIT]
        && tx_slot_i.ts == EFC_TS_ALIGN && tx_slot_i.bit_idx != EFC_BIT_ONE
        && !s_r.regs.tx1[TX1_PT_BIT] && !tx_slot_i.nonalign;
    endsequence

    sequence s_write_tx1;
        ce_i && wr_commit && s_r.addr == EFC_ADDR_TX1;
    endsequence

    a_ts0_internal_word: assert property (
        s_tx_slot_ts0_internal |=> tx_data_o == $past(tx_align_word_reg_i[tx_word_idx]))
        else $error("timeslot 0 bit not taken from align word");

    a_write_mask_read: assert property (
        s_write_tx1 |=> (s_r.regs.tx1 == ($past(s_r.wdata) & EFC_MASK_TX1))
                        && !s_r.regs.tx1[7])
        else $error("tx control one write not stored masked");

    a_ts16_all_ones: assert property (
        (ce_i && tx_slot_i.stb && tx_slot_i.ts == EFC_TS_SIG
         && s_r.regs.tx1[TX1_SA1_BIT]) |=> tx_data_o)
        else $error("timeslot 16 not forced to ones");

    a_unframed_rails: assert property (
        (ce_i && tx_slot_i.stb && s_r.regs.tx1[TX1_UA1_BIT])
        |=> (tx_positive_out_o != tx_negative_out_o) && tx_data_o)
        else $error("unframed all ones missing a pulse");

    a_rx_link_sa: assert property (
        (ce_i && rx_slot_i.stb && rx_is_sa && s_r.regs.rx2[rx_slot_i.bit_idx])
        |=> rx_link_valid_o && rx_link_out_o == $past(rx_src))
        else $error("selected Sa bit not reported on link");

    a_rx_link_quiet: assert property (
        (ce_i && !(rx_slot_i.stb && rx_is_sa)) |=> !rx_link_valid_o)
        else $error("link valid outside an Sa bit");

    a_shared_pin_sel: assert property (
        shared_pin_o == (s_r.regs.tx2[TX2_PIN_BIT] ? tx_clock_loss_i : rx_sync_loss_i))
        else $error("shared pin shows wrong loss source");

    a_sync_dir_pin: assert property (
        $rose(s_r.regs.tx1[TX1_DIR_BIT]) |-> !tx_sync_pin_oe_n_o ##1 $stable(tx_sync_pin_oe_n_o)
                                              || !ce_i || wr_commit)
        else $error("sync pin not driven when set as output");

    a_loopback_src: assert property (
        framer_loopback_o |-> rx_framer_data_o == tx_data_o)
        else $error("loopback does not feed transmit data to receive");

    a_clock_rate_lvl: assert property (
        (ce_i && wr_commit && s_r.addr == EFC_ADDR_RX2)
        |=> rx_backplane_clock_rate_o == $past(s_r.wdata[RX2_RATE_BIT]))
        else $error("clock rate level does not follow write");

    a_ts16_source_sel: assert property (
        (ce_i && tx_slot_i.stb && tx_slot_i.ts == EFC_TS_SIG && !s_r.regs.tx1[TX1_UA1_BIT]
         && !s_r.regs.tx1[TX1_SA1_BIT])
        |=> tx_data_o == $past(s_r.regs.tx1[TX1_TS16_BIT] ? tx_sig_reg_bit_i : tx_serial_in_i))
        else $error("timeslot 16 taken from wrong source");

    a_ts0_pass_through: assert property (
        (ce_i && tx_slot_i.stb && !s_r.regs.tx1[TX1_UA1_BIT] && tx_slot_i.ts == EFC_TS_ALIGN
         && tx_slot_i.bit_idx != EFC_BIT_ONE && s_r.regs.tx1[TX1_PT_BIT])
        |=> tx_data_o == $past(tx_serial_in_i))
        else $error("pass-through timeslot 0 bit not taken from serial input");

    // Si bit is the first bit of timeslot 0, so it is the top bit of either word
    a_si_internal_src: assert property (
        (ce_i && tx_slot_i.stb && !s_r.regs.tx1[TX1_UA1_BIT] && tx_slot_i.ts == EFC_TS_ALIGN
         && tx_slot_i.bit_idx == EFC_BIT_ONE && s_r.regs.tx1[TX1_SI_BIT])
        |=> tx_data_o == $past(tx_slot_i.nonalign ? tx_nonalign_word_reg_i[EFC_BIT_LAST]
                                                  : tx_align_word_reg_i[EFC_BIT_LAST]))
        else $error("Si bit not taken from internal words");

    a_tx_sa_link: assert property (
        (ce_i && tx_slot_i.stb && !s_r.regs.tx1[TX1_UA1_BIT] && tx_slot_i.ts == EFC_TS_ALIGN
         && tx_slot_i.nonalign && tx_slot_i.bit_idx >= EFC_SA_FIRST
         && !s_r.regs.tx1[TX1_PT_BIT] && s_r.regs.tx2[tx_slot_i.bit_idx])
        |=> tx_data_o == $past(tx_link_in_i))
        else $error("selected transmit Sa bit not taken from link pin");

    // Mode is read before a same-cycle write lands, hence the past value
    a_sync_mode_src: assert property (
        ce_i |=> tx_sync_pin_o == $past(s_r.regs.tx1[TX1_MODE_BIT] ? tx_mframe_start_i
                                                                   : tx_frame_start_i))
        else $error("sync pulse from wrong boundary");
endmodule : efc_ctrl_bank
`default_nettype wire

/* efc_host_model.sv */
// Host microcontroller model driving the multiplexed control port
`timescale 1ns/1ps
`default_nettype none
module efc_host_model
    import efc_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] ad_i,
    input  wire logic       ad_oe_n_i,
    output efc_bus_s        bus_o
);
    initial bus_o = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};
    // Address phase; latched by the device on the edge that sees ale low
    task automatic addr_ph(input logic [7:0] a);
        @(negedge mclk_i);
        bus_o.ale = 1'b1;
        bus_o.ad = a;
        @(negedge mclk_i);
        bus_o.ale = 1'b0;
    endtask : addr_ph
    // Write; unassigned bits forced low and Si select keeps pass-through clear
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [7:0] s);
        s = d;
        case (a)
            EFC_ADDR_RX2: s = d & EFC_MASK_RX2;
            EFC_ADDR_TX1: s = d & EFC_MASK_TX1;
            EFC_ADDR_TX2: s = d & EFC_MASK_TX2;
            default: s = d;
        endcase
        if (a == EFC_ADDR_TX1 && s[TX1_SI_BIT]) s[TX1_PT_BIT] = 1'b0;
        addr_ph(a);
        @(negedge mclk_i);
        bus_o.wr_n = 1'b0;
        bus_o.ad = s;
        @(negedge mclk_i);
        bus_o.wr_n = 1'b1;
        bus_o.ad = ~s; // Released bus no longer shows the data
    endtask : wr
    // Read; the bus is released, so ad carries an inverted pattern meanwhile
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_ph(a);
        @(negedge mclk_i);
        bus_o.rd_n = 1'b0;
        bus_o.ad = ~a;
        d = 8'hXX;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk_i);
            if (ad_oe_n_i === 1'b0) begin
                d = ad_i;
                break;
            end
        end
        bus_o.rd_n = 1'b1;
    endtask : rd
endmodule : efc_host_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the E1 framer control bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import efc_pkg::*;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    efc_bus_s   bus;
    efc_slot_s  sl;
    logic [7:0] ad, af, naf, m[4], s, d;
    logic       oe_n, ser, lnk, sig, fs, mfs, tbm, rbm, rxd, pin_i, sl_i, cl_i;
    logic       txd, tp, tn, tcb, spo, spoe, sps, rfd, rlo, rlv, rcb, shp;
    logic [9:0] cfg;
    int         failures = 0, n_tests = 0, lastp;
    logic       e, pt, ce = 1'b1;
    initial forever #12.5 mclk = ~mclk;
    efc_host_model i_host (.mclk_i(mclk), .ad_i(ad), .ad_oe_n_i(oe_n), .bus_o(bus));
    efc_ctrl_bank i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce), .bus_i(bus),
        .ad_o(ad), .ad_oe_n_o(oe_n), .tx_slot_i(sl), .tx_serial_in_i(ser),
        .tx_link_in_i(lnk), .tx_align_word_reg_i(af), .tx_nonalign_word_reg_i(naf),
        .tx_sig_reg_bit_i(sig), .tx_frame_start_i(fs), .tx_mframe_start_i(mfs),
        .tx_blk_map_i(tbm), .tx_data_o(txd), .tx_positive_out_o(tp),
        .tx_negative_out_o(tn), .tx_channel_block_out_o(tcb), .tx_sync_pin_i(pin_i),
        .tx_sync_pin_o(spo), .tx_sync_pin_oe_n_o(spoe), .tx_sync_seen_o(sps),
        .rx_slot_i(sl), .rx_line_data_i(rxd), .rx_blk_map_i(rbm),
        .rx_framer_data_o(rfd), .rx_link_out_o(rlo), .rx_link_valid_o(rlv),
        .rx_channel_block_out_o(rcb), .rx_sync_loss_i(sl_i), .tx_clock_loss_i(cl_i),
        .shared_pin_o(shp), .rx_backplane_clock_rate_o(cfg[0]),
        .rx_slip_buffer_enable_o(cfg[1]), .tx_sync_mode_o(cfg[2]),
        .auto_ebit_enable_o(cfg[3]), .rx_signaling_mode_o(cfg[4]),
        .framer_loopback_o(cfg[5]), .tx_zero_sub_enable_o(cfg[6]),
        .rx_zero_sub_enable_o(cfg[7]), .tx_multiframe_check_enable_o(cfg[8]),
        .rx_multiframe_check_enable_o(cfg[9]));
    // Comparison with counting
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // Reference transmit bit from the control fields
    function automatic logic tx_ref(efc_slot_s q);
        logic w;
        w = q.nonalign ? naf[3'h7 - q.bit_idx] : af[3'h7 - q.bit_idx];
        if (m[1][TX1_UA1_BIT]) return 1'b1;
        if (q.ts == EFC_TS_SIG) return m[1][TX1_SA1_BIT] | (m[1][TX1_TS16_BIT] ? sig : ser);
        if (q.ts != EFC_TS_ALIGN) return ser;
        if (q.bit_idx == EFC_BIT_ONE) return m[1][TX1_SI_BIT] ? w : ser;
        if (m[1][TX1_PT_BIT]) return ser;
        if (q.nonalign && q.bit_idx >= EFC_SA_FIRST && m[2][q.bit_idx]) return lnk;
        return w;
    endfunction : tx_ref
    // Watchdog sized well beyond the expected run of about twelve hundred cycles
    initial begin
        #(25 * 50000);
        failures++;
        wrap_up();
    end
    initial begin
        sl = '0; {ser, lnk, sig, fs, mfs, tbm, rbm, rxd, pin_i, sl_i, cl_i} = '0;
        af = 8'h00; naf = 8'h00; m = '{default: 8'h00}; lastp = -1;
        void'($urandom(1));
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        // Reset values and an unmapped location
        for (int a = 8'h11; a <= 8'h15; a++) begin
            i_host.rd(8'(a), d);
            chk("reset read", d, EFC_RST_VAL);
        end
        i_host.wr(8'h15, 8'hFF, s);
        // Clock enable low freezes the port, so this write never lands
        @(negedge mclk);
        ce = 1'b0;
        i_host.wr(EFC_ADDR_CC1, 8'hFF, s);
        @(negedge mclk);
        ce = 1'b1;
        i_host.rd(EFC_ADDR_CC1, d);
        chk("frozen write", d, EFC_RST_VAL);
        chk("frozen config", cfg, 10'h000);
        $display("test reset and unmapped done");
        for (int r = 0; r < 10; r++) begin
            // Random configuration, read back and the levels it drives
            for (int a = 0; a < 4; a++) begin
                i_host.wr(8'h11 + 8'(a), 8'($urandom), s);
                m[a] = s;
            end
            for (int a = 0; a < 5; a++) begin
                i_host.rd(8'h11 + 8'(a), d);
                chk("readback", d, (a < 4) ? m[a] : EFC_RD_NONE);
            end
            chk("config", cfg, {m[3][0], m[3][4], m[3][2], m[3][6], m[3][7], m[3][3],
                m[2][1], m[1][1], m[0][1], m[0][2]});
            // Bit slots, with slot numbers weighted toward 0, 16 and 26
            for (int k = 0; k < 40; k++) begin
                @(negedge mclk);
                pt = txd; // Loopback feeds the bit sent before this slot
                sl = efc_slot_s'(10'($urandom));
                sl.stb = 1'b1;
                case ($urandom % 4)
                    0: sl.ts = EFC_TS_ALIGN;
                    1: sl.ts = EFC_TS_SIG;
                    2: sl.ts = EFC_TS_BLOCK;
                    default: ;
                endcase
                {ser, lnk, sig, fs, mfs, tbm, rbm, rxd, pin_i, sl_i, cl_i} = 11'($urandom);
                {af, naf} = 16'($urandom);
                @(negedge mclk);
                sl.stb = 1'b0;
                e = tx_ref(sl);
                chk("tx data", txd, e);
                chk("rail sum", tp | tn, e);
                chk("rail excl", tp & tn, 1'b0);
                if (e && lastp >= 0) chk("rail alt", tp, !lastp[0]);
                if (e) lastp = tp;
                chk("tx blk", tcb, tbm | (m[3][CC1_TBLK_BIT] && sl.ts == EFC_TS_BLOCK
                    && sl.bit_idx == EFC_BIT_ONE));
                chk("rx blk", rcb, rbm | (m[3][CC1_RBLK_BIT] && sl.ts == EFC_TS_BLOCK
                    && sl.bit_idx == EFC_BIT_ONE));
                e = sl.ts == EFC_TS_ALIGN && sl.nonalign && sl.bit_idx >= EFC_SA_FIRST
                    && m[0][sl.bit_idx];
                chk("rx link vld", rlv, e);
                if (e) chk("rx link", rlo, m[3][CC1_LOOP_BIT] ? pt : rxd);
                chk("rx framer", rfd, m[3][CC1_LOOP_BIT] ? txd : rxd);
                chk("shared pin", shp, m[2][TX2_PIN_BIT] ? cl_i : sl_i);
                chk("sync oe", spoe, !m[1][TX1_DIR_BIT]);
                if (m[1][TX1_DIR_BIT]) chk("sync out", spo,
                    m[1][TX1_MODE_BIT] ? mfs : fs);
                chk("sync seen", sps, m[1][TX1_DIR_BIT] ? spo : pin_i);
            end
            $display("test round %0d done", r);
        end
        // Reset in mid-run returns every register and level to zero
        @(negedge mclk);
        rst_n = 1'b0;
        @(negedge mclk);
        rst_n = 1'b1;
        for (int a = 0; a < 4; a++) begin
            i_host.rd(8'h11 + 8'(a), d);
            chk("mid reset read", d, EFC_RST_VAL);
        end
        chk("mid reset config", cfg, 10'h000);
        chk("mid reset sync oe", spoe, 1'b1);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
